// *** core/sar_consts.svh ***
// Timing and format constants for the converter readout block
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

`define SAR_CLK_NS            5
`define SAR_RES_BITS          12
`define SAR_ADC_NS            247
`define SAR_T_WAKE_NAP_NS     50
`define SAR_T_WAKE_SLEEP_MS   1.1
`define SAR_SLEEP_PULSES      3'h4
`define SAR_CNT_ZERO          3'h0
`define SAR_CNT_ONE           3'h1
// Least time rounds up, nap wake rounds down, sleep wake rounds to nearest
`define SAR_ADC_CYC           ((`SAR_ADC_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_WAKE_NAP_CYC      (`SAR_T_WAKE_NAP_NS / `SAR_CLK_NS)
`define SAR_WAKE_SLEEP_CYC    (int'(`SAR_T_WAKE_SLEEP_MS * 1.0e6 / `SAR_CLK_NS))

`endif

// *** core/sar_pkg.sv ***
// Types shared by the converter readout block
package sar_pkg;
  // Gray along acquire, convert, nap, wake, acquire
  typedef enum logic [2:0] {
    ST_ACQ   = 3'h0,
    ST_BUSY  = 3'h1,
    ST_NAP   = 3'h3,
    ST_WAKE  = 3'h2,
    ST_SLEEP = 3'h6
  } sar_state_e;
endpackage

// *** core/sar_sync_edge.sv ***
// Two-flop pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module sar_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous pin
  input  wire logic pin,
  // Synchronised view
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule // sar_sync_edge
`default_nettype wire

// *** core/sar_readout.sv ***
// Control and serial readout of a 12-bit sampling converter
`timescale 1ns/10ps
`default_nettype none
`include "sar_consts.svh"
// How it works
// - Strobe rising edge starts a conversion timed by the core clock.
// - After conversion the block drops into nap by itself.
// - Serial output is high impedance while the strobe is high.
// - Strobe falling edge enables the output and presents the MSB.
// - Each shift-clock falling edge presents the next lower bit.
// - Twelve bits MSB first, then zeros on further falling edges.
// - Shifted bits belong to the conversion just ended, no latency.
// - Strobe low puts the sample-and-hold into tracking.
// - From nap the block is ready within about 50 ns of a wake.
// - Two strobe pulses with shift clock static leave the block in nap.
// - Four strobe pulses with shift clock static enter sleep, bias off.
// - One shift-clock rise wakes the block from nap or sleep.
module sar_readout #(
  parameter int RES_BITS       = `SAR_RES_BITS,
  parameter int WAKE_SLEEP_CYC = `SAR_WAKE_SLEEP_CYC
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Host pins
  input  wire logic                convert_strobe,
  input  wire logic                shift_clk,
  output logic                     serial_result_out,
  output logic                     serial_result_oe,
  // Converter core
  input  wire logic [RES_BITS-1:0] adc_code,
  output logic                     sample_track,
  output logic                     adc_busy,
  output logic                     bias_en,
  output logic                     nap_active,
  output logic                     ready
);
  import sar_pkg::*;

  localparam int ADC_CYC  = `SAR_ADC_CYC;
  localparam int NAP_CYC  = `SAR_WAKE_NAP_CYC;
  localparam int TMAX     = (WAKE_SLEEP_CYC > ADC_CYC) ? WAKE_SLEEP_CYC : ADC_CYC;
  localparam int TW       = $clog2(TMAX + 1);
  localparam int BW       = $clog2(RES_BITS + 2);

  sar_state_e          state_q;
  sar_state_e          state_d;
  logic [TW-1:0]       timer_q;
  logic [TW-1:0]       timer_d;
  logic [2:0]          rise_cnt_q;
  logic [RES_BITS-1:0] result_q;
  logic [RES_BITS-1:0] shift_q;
  logic [BW-1:0]       bit_cnt_q;
  wire                 cv_lvl;
  wire                 cv_rise;
  wire                 cv_fall;
  wire                 sk_lvl;
  wire                 sk_rise;
  wire                 sk_fall;

  sar_sync_edge u_cv_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .pin   (convert_strobe),
    .level (cv_lvl),
    .rise  (cv_rise),
    .fall  (cv_fall)
  );

  sar_sync_edge u_sk_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .pin   (shift_clk),
    .level (sk_lvl),
    .rise  (sk_rise),
    .fall  (sk_fall)
  );

  wire                sk_edge    = sk_rise | sk_fall;
  wire                timer_zero = (timer_q == '0);
  wire                adc_done   = (state_q == ST_BUSY) && timer_zero;
  wire                sleep_req  = cv_rise && (rise_cnt_q == `SAR_SLEEP_PULSES - `SAR_CNT_ONE);
  wire                adc_start  = cv_rise && (state_q != ST_SLEEP) && !sleep_req;
  // Result forwarded in the same cycle when the strobe falls right at the end
  wire [RES_BITS-1:0] load_word  = adc_done ? adc_code : result_q;
  wire                shifting   = sk_fall && serial_result_oe && !cv_lvl && !cv_fall;
  wire [2:0]          rise_cnt_d =
    sk_edge ? `SAR_CNT_ZERO :
    (cv_rise && rise_cnt_q != `SAR_SLEEP_PULSES) ? rise_cnt_q + `SAR_CNT_ONE :
    rise_cnt_q;

  always_comb begin
    state_d = state_q;
    timer_d = timer_zero ? timer_q : timer_q - 1'b1;
    if (sleep_req) begin
      state_d = ST_SLEEP;
      timer_d = '0;
    end else if (adc_start) begin
      state_d = ST_BUSY;
      timer_d = TW'(ADC_CYC - 1);
    end else begin
      case (state_q)
        ST_BUSY: begin
          if (adc_done) begin
            state_d = ST_NAP;
          end
        end
        ST_NAP: begin
          if (sk_rise) begin
            state_d = ST_WAKE;
            timer_d = TW'(NAP_CYC - 1);
          end
        end
        ST_SLEEP: begin
          if (sk_rise) begin
            state_d = ST_WAKE;
            timer_d = TW'(WAKE_SLEEP_CYC - 1);
          end
        end
        ST_WAKE: begin
          if (timer_zero) begin
            state_d = ST_ACQ;
          end
        end
        ST_ACQ: begin
          state_d = ST_ACQ;
        end
        default: begin
          state_d = ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q     <= ST_ACQ;
      timer_q     <= '0;
      rise_cnt_q  <= `SAR_CNT_ZERO;
      adc_busy    <= 1'b0;
      bias_en     <= 1'b1;
      nap_active  <= 1'b0;
      ready       <= 1'b1;
    end else begin
      state_q     <= state_d;
      timer_q     <= timer_d;
      rise_cnt_q  <= rise_cnt_d;
      adc_busy    <= (state_d == ST_BUSY);
      bias_en     <= (state_d != ST_SLEEP);
      nap_active  <= (state_d == ST_NAP);
      ready       <= (state_d == ST_ACQ);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_q         <= '0;
      shift_q          <= '0;
      bit_cnt_q        <= '0;
      serial_result_oe <= 1'b0;
      sample_track     <= 1'b1;
    end else begin
      if (adc_done) begin
        result_q <= adc_code;
      end
      sample_track <= ~cv_lvl;
      if (cv_lvl) begin
        serial_result_oe <= 1'b0;
      end else if (cv_fall) begin
        serial_result_oe <= 1'b1;
        shift_q          <= load_word;
        bit_cnt_q        <= BW'(1);
      end else if (shifting) begin
        shift_q <= {shift_q[RES_BITS-2:0], 1'b0};
        if (bit_cnt_q <= BW'(RES_BITS)) begin
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
      end
    end
  end

  assign serial_result_out = shift_q[RES_BITS-1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_adc_start;
    adc_start |=> (state_q == ST_BUSY) && adc_busy;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("strobe rise did not start conversion");

  property p_adc_len;
    (state_q == ST_BUSY) && ($past(state_q) != ST_BUSY) |-> timer_q == TW'(ADC_CYC - 1);
  endproperty
  a_adc_len: assert property (p_adc_len) else $error("conversion timer not loaded to minimum");

  property p_auto_nap;
    adc_done && !cv_rise |=> (state_q == ST_NAP) && nap_active && !adc_busy;
  endproperty
  a_auto_nap: assert property (p_auto_nap) else $error("no nap after conversion");

  property p_hiz;
    cv_lvl |=> !serial_result_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while strobe high");

  property p_msb;
    cv_fall |=> serial_result_oe && (shift_q == $past(load_word));
  endproperty
  a_msb: assert property (p_msb) else $error("MSB of current result not presented");

  property p_shift;
    shifting |=> serial_result_out == $past(shift_q[RES_BITS-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("next bit missing after shift fall");

  property p_zeros;
    serial_result_oe && (bit_cnt_q > BW'(RES_BITS)) |-> !serial_result_out;
  endproperty
  a_zeros: assert property (p_zeros) else $error("nonzero bit after last result bit");

  sequence s_readout_open;
    cv_fall ##1 !cv_lvl;
  endsequence
  property p_track;
    s_readout_open |-> sample_track && serial_result_oe;
  endproperty
  a_track: assert property (p_track) else $error("not tracking after strobe fall");

  property p_wake_nap;
    (state_q == ST_NAP) && sk_rise && !cv_rise |-> ##[1:12] (ready || adc_busy);
  endproperty
  a_wake_nap: assert property (p_wake_nap) else $error("nap wake too slow");

  property p_sleep;
    sleep_req |=> (state_q == ST_SLEEP) ##0 !bias_en [*2];
  endproperty
  a_sleep: assert property (p_sleep) else $error("four pulses did not enter sleep");

  property p_rise_clear;
    sk_edge |=> rise_cnt_q == `SAR_CNT_ZERO;
  endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("strobe count not cleared by shift clock");

endmodule // sar_readout
`default_nettype wire

// *** dv/sar_host_model.sv ***
// Host model: drives strobe and shift clock, captures the serial result
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
  // Clock
  input  wire logic core_clk,
  // Host pins
  output logic      convert_strobe,
  output logic      shift_clk,
  input  wire logic serial_result_out,
  input  wire logic serial_result_oe
);
  initial begin
    convert_strobe = 1'b0;
    shift_clk      = 1'b0;
  end
  // Shift clock stays still while the strobe moves
  task automatic strobe(input logic v, input int n);
    convert_strobe = v;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic shift(input logic v, input int n);
    shift_clk = v;
    repeat (n) @(negedge core_clk);
  endtask
  // A released output reads as unknown, so a missing enable fails the word
  task automatic read(input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < n; i++) begin
      w = {w[14:0], serial_result_oe ? serial_result_out : 1'bx};
      shift(1'b1, 16);
      shift(1'b0, 16);
    end
    repeat (4) @(negedge core_clk);
  endtask
endmodule // sar_host_model
`default_nettype wire

// *** dv/tb_sampling_adc_serial_readout.sv ***
// Testbench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module tb_sampling_adc_serial_readout;
  localparam int WAKE_CYC = 40;
  logic        core_clk;
  logic        rst_n;
  logic        convert_strobe;
  logic        shift_clk;
  logic        serial_result_out;
  logic        serial_result_oe;
  logic [11:0] adc_code;
  logic        sample_track;
  logic        adc_busy;
  logic        bias_en;
  logic        nap_active;
  logic        ready;
  int          err_count;
  int          comparisons;
  int          cyc;

  sar_readout #(.RES_BITS(12), .WAKE_SLEEP_CYC(WAKE_CYC)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe), .adc_code(adc_code),
    .sample_track(sample_track), .adc_busy(adc_busy), .bias_en(bias_en), .nap_active(nap_active),
    .ready(ready));
  sar_host_model host (
    .core_clk(core_clk), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Status bits: oe, track, busy, bias, nap, ready
  function automatic logic [15:0] st();
    return {10'h000, serial_result_oe, sample_track, adc_busy, bias_en, nap_active, ready};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Convert, then read 14 bits: twelve of result, two trailing zeros
  task automatic conversion_interval(input logic [11:0] code);
    logic [15:0] w;
    adc_code = code;
    host.strobe(1'b1, 10);
    chk(st() & 16'h0038, 16'h0008);
    host.strobe(1'b1, 50);
    chk(st() & 16'h002A, 16'h0002);
    host.strobe(1'b0, 6);
    chk(st() & 16'h0038, 16'h0030);
    host.read(14, w);
    chk(w, {2'h0, code, 2'h0});
  endtask
  task automatic t_nap();
    host.strobe(1'b1, 4);
    host.strobe(1'b0, 4);
    host.strobe(1'b1, 4);
    host.strobe(1'b0, 60);
    chk(st() & 16'h000E, 16'h0006);
    host.shift(1'b1, 5);
    chk(st() & 16'h0001, 16'h0000);
    // Ready is due about 50 ns after the rise plus three sync edges
    host.shift(1'b1, 10);
    chk(st() & 16'h0003, 16'h0001);
    host.shift(1'b0, 16);
  endtask
  task automatic t_sleep();
    repeat (4) begin
      host.strobe(1'b1, 4);
      host.strobe(1'b0, 4);
    end
    chk(st() & 16'h0004, 16'h0000);
    // A strobe while asleep must not start a conversion
    host.strobe(1'b1, 10);
    chk(st() & 16'h000C, 16'h0000);
    host.strobe(1'b0, 10);
    host.shift(1'b1, 20);
    chk(st() & 16'h0001, 16'h0000);
    host.shift(1'b1, WAKE_CYC);
    chk(st() & 16'h0005, 16'h0005);
    host.shift(1'b0, 16);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    rst_n       = 1'b0;
    adc_code    = 12'h000;
    err_count   = 0;
    comparisons = 0;
    cyc         = 0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk(st(), 16'h0015);
    conversion_interval(12'hA5C);
    conversion_interval(12'h3A1);
    conversion_interval(12'hFFF);
    t_nap();
    t_sleep();
    conversion_interval(12'h001);
    test_done();
  end
endmodule // tb_sampling_adc_serial_readout
`default_nettype wire
